// *** qbp_port_ctl.sv ***
`timescale 1ns/10ps
`include "qbp_defs.svh"
`default_nettype none
module qbp_port_ctl
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [7:0] p1_pin_hi_i,
    input wire logic [7:0] p2_pin_hi_i,
    input wire logic [7:0] p3_pin_hi_i,
    input wire logic code_fetch_source_pin_n_i,
    input wire logic ext_fetch_i,
    input wire logic addr16_i,
    input wire logic bus_lo_oe_i,
    input wire logic [7:0] bus_addr_lo_i,
    input wire logic [7:0] bus_addr_hi_i,
    input wire logic [7:0] p1_alt_out_i,
    input wire logic [7:0] p3_alt_out_i,
    output logic [7:0] p0_pulldown_o,
    output logic [7:0] p0_pullup_o,
    output qbp_pkg::qbp_qdrv_s p1_drv_o,
    output qbp_pkg::qbp_qdrv_s p2_drv_o,
    output qbp_pkg::qbp_qdrv_s p3_drv_o,
    output qbp_pkg::qbp_ssc_ctl_s ssc_ctl_o,
    output qbp_pkg::qbp_p1_alt_s p1_alt_in_o,
    output qbp_pkg::qbp_p3_alt_s p3_alt_in_o
);
    logic [7:0] lat0;
    logic [7:0] lat1;
    logic [7:0] lat2;
    logic [7:0] lat3;
    logic [2:0] ctrl;
    logic [3:0] phase;
    logic [7:0] pend1;
    logic [7:0] pend2;
    logic [7:0] pend3;
    logic [7:0] boost1;
    logic [7:0] boost2;
    logic [7:0] boost3;
    logic [7:0] s1a;
    logic [7:0] s1b;
    logic [7:0] s2a;
    logic [7:0] s2b;
    logic [7:0] s3a;
    logic [7:0] s3b;
    logic bus_sel;
    logic req;
    logic take;
    logic wr_p0;
    logic wr_p1;
    logic wr_p2;
    logic wr_p3;
    logic [7:0] wd;
    logic ssc_en;
    logic ssc_master;
    logic tx_permit;
    logic sel_active;
    logic [7:0] eff1;
    logic [7:0] eff3;
    logic [31:0] next_rdata;
    logic [7:0] next_p0_pd;
    logic [7:0] next_p0_pu;
    qbp_pkg::qbp_qdrv_s next_p1;
    qbp_pkg::qbp_qdrv_s next_p2;
    qbp_pkg::qbp_qdrv_s next_p3;
    qbp_pkg::qbp_ssc_ctl_s next_ssc;

    // Driver state from latch, boost window and sensed level
    function automatic qbp_pkg::qbp_drv_e q_state(input logic l,
        input logic b, input logic s);
        if (!l)
            q_state = qbp_pkg::QBP_OUTPUT_LOW;
        else if (b)
            q_state = qbp_pkg::QBP_FORCED_HIGH;
        else if (s)
            q_state = qbp_pkg::QBP_INPUT_HIGH;
        else
            q_state = qbp_pkg::QBP_INPUT_LOW;
    endfunction

    // Fets per state: pulldown, boost, hold, sensed
    function automatic logic [3:0] q_fets(input qbp_pkg::qbp_drv_e st);
        case (st)
            qbp_pkg::QBP_INPUT_LOW: q_fets = 4'h2;
            qbp_pkg::QBP_INPUT_HIGH: q_fets = 4'h3;
            qbp_pkg::QBP_FORCED_HIGH: q_fets = 4'h7;
            qbp_pkg::QBP_OUTPUT_LOW: q_fets = 4'h8;
            default: q_fets = 4'h8;
        endcase
    endfunction

    assign bus_sel = !code_fetch_source_pin_n_i || ext_fetch_i;
    assign req = avs_read_i || avs_write_i;
    assign take = req && !avs_waitrequest_o;
    assign wd = avs_writedata_i[7:0];
    assign wr_p0 = take && avs_write_i && avs_address_i == `QBP_OFF_P0;
    assign wr_p1 = take && avs_write_i && avs_address_i == `QBP_OFF_P1;
    assign wr_p2 = take && avs_write_i && avs_address_i == `QBP_OFF_P2;
    assign wr_p3 = take && avs_write_i && avs_address_i == `QBP_OFF_P3;
    assign ssc_en = ctrl[`QBP_CTL_EN];
    assign ssc_master = ctrl[`QBP_CTL_MASTER];
    assign tx_permit = ctrl[`QBP_CTL_PERMIT];
    assign sel_active = !s1b[`QBP_SEL_BIT];
    // Peripheral outputs reach pins only through a latch holding one
    assign eff1 = lat1 & p1_alt_out_i;
    assign eff3 = lat3 & p3_alt_out_i;

    // One wait cycle per access, then a single ready cycle
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            avs_waitrequest_o <= 1'b1;
        else
            avs_waitrequest_o <= !(req && avs_waitrequest_o);
    end

    always_comb
    begin
        next_rdata = 32'h0;
        case (avs_address_i)
            `QBP_OFF_P0: next_rdata = {24'h0, lat0};
            `QBP_OFF_P1: next_rdata = {24'h0, lat1 & `QBP_P1_MASK};
            `QBP_OFF_P2: next_rdata = {24'h0, lat2};
            `QBP_OFF_P3: next_rdata = {24'h0, lat3};
            `QBP_OFF_CTRL: next_rdata = {29'h0, ctrl};
            `QBP_OFF_STAT:
                next_rdata = {7'h0, bus_sel, s3b, s2b, s1b & `QBP_P1_MASK};
            default: next_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            avs_readdata_o <= 32'h0;
        else if (avs_read_i && avs_waitrequest_o)
            avs_readdata_o <= next_rdata;
    end

    // Latches: all ones at reset; bus mode refills low port
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            lat0 <= `QBP_LATCH_RST;
            lat1 <= `QBP_LATCH_RST;
            lat2 <= `QBP_LATCH_RST;
            lat3 <= `QBP_LATCH_RST;
        end
        else
        begin
            if (bus_sel)
                lat0 <= `QBP_LATCH_RST;
            else if (wr_p0)
                lat0 <= wd;
            if (wr_p1)
                lat1 <= wd | ~`QBP_P1_MASK;
            if (wr_p2)
                lat2 <= wd;
            if (wr_p3)
                lat3 <= wd;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ctrl <= `QBP_CTRL_RST;
        else if (take && avs_write_i && avs_address_i == `QBP_OFF_CTRL)
            ctrl <= avs_writedata_i[2:0];
    end

    // Phase counter, S1P1 at zero
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            phase <= `QBP_PHASE_S1P1;
        else if (phase == `QBP_PHASE_LAST)
            phase <= `QBP_PHASE_S1P1;
        else
            phase <= phase + 4'h1;
    end

    // Only zero-to-one edges arm the boost; new arming beats the clear
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pend1 <= 8'h00;
            pend2 <= 8'h00;
            pend3 <= 8'h00;
        end
        else
        begin
            pend1 <= (phase == `QBP_PHASE_S1P1 ? 8'h00 : pend1)
                | (wr_p1 ? wd & ~lat1 & `QBP_P1_MASK : 8'h00);
            pend2 <= (phase == `QBP_PHASE_S1P1 ? 8'h00 : pend2)
                | (wr_p2 ? wd & ~lat2 : 8'h00);
            pend3 <= (phase == `QBP_PHASE_S1P1 ? 8'h00 : pend3)
                | (wr_p3 ? wd & ~lat3 : 8'h00);
        end
    end

    // Boost window covers both phases of state S1
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            boost1 <= 8'h00;
            boost2 <= 8'h00;
            boost3 <= 8'h00;
        end
        else if (phase == `QBP_PHASE_S1P1)
        begin
            boost1 <= pend1;
            boost2 <= pend2;
            boost3 <= pend3;
        end
        else if (phase == `QBP_BOOST_PHASES)
        begin
            boost1 <= 8'h00;
            boost2 <= 8'h00;
            boost3 <= 8'h00;
        end
    end

    // Sensed-high levels; first stage feeds the second only
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1a <= 8'h00;
            s1b <= 8'h00;
            s2a <= 8'h00;
            s2b <= 8'h00;
            s3a <= 8'h00;
            s3b <= 8'h00;
        end
        else
        begin
            s1a <= p1_pin_hi_i;
            s1b <= s1a;
            s2a <= p2_pin_hi_i;
            s2b <= s2a;
            s3a <= p3_pin_hi_i;
            s3b <= s3a;
        end
    end

    // Quasi-bidirectional driver selection
    always_comb
    begin
        logic [3:0] f;
        f = 4'h0;
        next_p1 = '0;
        next_p2 = '0;
        next_p3 = '0;
        for (int i = 0; i < 8; i++)
        begin
            f = q_fets(q_state(eff1[i], boost1[i], s1b[i]));
            {next_p1.strong_pulldown_fet[i], next_p1.boost_pullup_fet[i],
                next_p1.hold_pullup_fet[i],
                next_p1.sensed_pullup_fet[i]} = f;
            f = q_fets(q_state(lat2[i], boost2[i], s2b[i]));
            if (bus_sel && addr16_i)
                f = bus_addr_hi_i[i] ? 4'h4 : 4'h8;
            {next_p2.strong_pulldown_fet[i], next_p2.boost_pullup_fet[i],
                next_p2.hold_pullup_fet[i],
                next_p2.sensed_pullup_fet[i]} = f;
            f = q_fets(q_state(eff3[i], boost3[i], s3b[i]));
            {next_p3.strong_pulldown_fet[i], next_p3.boost_pullup_fet[i],
                next_p3.hold_pullup_fet[i],
                next_p3.sensed_pullup_fet[i]} = f;
        end
        // Bits 7:6 of port 1 have no pins
        next_p1.strong_pulldown_fet[7:6] = 2'h0;
        next_p1.hold_pullup_fet[7:6] = 2'h0;
        next_p1.sensed_pullup_fet[7:6] = 2'h0;
        next_p1.boost_pullup_fet[7:6] = 2'h0;
        // Serial pins: push-pull drives both ways, tristate drives none
        if (next_ssc.sclk_pushpull)
        begin
            next_p1.strong_pulldown_fet[`QBP_SCLK_BIT] =
                !eff1[`QBP_SCLK_BIT];
            next_p1.boost_pullup_fet[`QBP_SCLK_BIT] = eff1[`QBP_SCLK_BIT];
        end
        if (next_ssc.sclk_pushpull || next_ssc.sclk_tristate)
        begin
            next_p1.hold_pullup_fet[`QBP_SCLK_BIT] = 1'b0;
            next_p1.sensed_pullup_fet[`QBP_SCLK_BIT] = 1'b0;
        end
        if (next_ssc.sclk_tristate)
        begin
            next_p1.strong_pulldown_fet[`QBP_SCLK_BIT] = 1'b0;
            next_p1.boost_pullup_fet[`QBP_SCLK_BIT] = 1'b0;
        end
        if (next_ssc.tx_pushpull)
        begin
            next_p1.strong_pulldown_fet[`QBP_TX_BIT] = !eff1[`QBP_TX_BIT];
            next_p1.boost_pullup_fet[`QBP_TX_BIT] = eff1[`QBP_TX_BIT];
            next_p1.hold_pullup_fet[`QBP_TX_BIT] = 1'b0;
            next_p1.sensed_pullup_fet[`QBP_TX_BIT] = 1'b0;
        end
        if (next_ssc.tx_tristate)
        begin
            next_p1.strong_pulldown_fet[`QBP_TX_BIT] = 1'b0;
            next_p1.boost_pullup_fet[`QBP_TX_BIT] = 1'b0;
        end
        if (next_ssc.rx_tristate)
        begin
            next_p1.strong_pulldown_fet[`QBP_RX_BIT] = 1'b0;
            next_p1.boost_pullup_fet[`QBP_RX_BIT] = 1'b0;
            next_p1.hold_pullup_fet[`QBP_RX_BIT] = 1'b0;
            next_p1.sensed_pullup_fet[`QBP_RX_BIT] = 1'b0;
        end
        if (next_ssc.sel_tristate)
        begin
            next_p1.strong_pulldown_fet[`QBP_SEL_BIT] = 1'b0;
            next_p1.boost_pullup_fet[`QBP_SEL_BIT] = 1'b0;
            next_p1.hold_pullup_fet[`QBP_SEL_BIT] = 1'b0;
            next_p1.sensed_pullup_fet[`QBP_SEL_BIT] = 1'b0;
        end
    end

    always_comb
    begin
        next_ssc.sclk_pushpull = ssc_en && ssc_master;
        next_ssc.sclk_tristate = ssc_en && !ssc_master;
        next_ssc.tx_pushpull = ssc_en;
        next_ssc.tx_tristate = ssc_en && !ssc_master
            && !(sel_active && tx_permit);
        next_ssc.rx_tristate = ssc_en;
        next_ssc.sel_tristate = ssc_en && !ssc_master;
    end

    // Open-drain port; pullup only while the bus emits ones
    always_comb
    begin
        if (bus_sel)
        begin
            next_p0_pd = bus_lo_oe_i ? ~bus_addr_lo_i : 8'h00;
            next_p0_pu = bus_lo_oe_i ? bus_addr_lo_i : 8'h00;
        end
        else
        begin
            next_p0_pd = ~lat0;
            next_p0_pu = 8'h00;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            p0_pulldown_o <= 8'h00;
            p0_pullup_o <= 8'h00;
            p1_drv_o <= '0;
            p2_drv_o <= '0;
            p3_drv_o <= '0;
            ssc_ctl_o <= '0;
        end
        else
        begin
            p0_pulldown_o <= next_p0_pd;
            p0_pullup_o <= next_p0_pu;
            p1_drv_o <= next_p1;
            p2_drv_o <= next_p2;
            p3_drv_o <= next_p3;
            ssc_ctl_o <= next_ssc;
        end
    end

    // Alternate inputs see the pin only through a latch holding one
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            p1_alt_in_o <= '0;
            p3_alt_in_o <= '0;
        end
        else
        begin
            p1_alt_in_o <= {s1b[0] & lat1[0], s1b[1] & lat1[1],
                s1b[2] & lat1[2], s1b[3] & lat1[3],
                s1b[5] & lat1[5]};
            p3_alt_in_o <= {s3b[1] & lat3[1], s3b[2] & lat3[2],
                s3b[3] & lat3[3], s3b[4] & lat3[4],
                s3b[5] & lat3[5]};
        end
    end

    chk_pd_latch: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        p3_drv_o.strong_pulldown_fet == ~$past(eff3))
        else $error("pulldown does not follow latch");
    chk_boost_s1: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (boost3 != 8'h00) |-> (phase == 4'h1 || phase == 4'h2))
        else $error("boost outside state S1");
    chk_hold_one: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> p3_drv_o.hold_pullup_fet == $past(eff3))
        else $error("hold pullup does not follow latch");
    chk_sensed_pin: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        p3_drv_o.sensed_pullup_fet == $past(eff3 & (s3b | boost3)))
        else $error("sensed pullup wrong");
    chk_forced_two: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(boost3[0]) |-> ##1 boost3[0] ##1 !boost3[0]
            ##1 p3_drv_o.boost_pullup_fet[0] == 1'b0)
        else $error("forced high not two phases");
    chk_no_reboost: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (wr_p3 && wd == lat3 && pend3 == 8'h00
            && phase != `QBP_PHASE_LAST) |=> pend3 == 8'h00)
        else $error("rewrite of one armed the boost");
    chk_sclk_mode: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ##1 ssc_ctl_o.sclk_pushpull == $past(ssc_en && ssc_master)
            && ssc_ctl_o.sclk_tristate == $past(ssc_en && !ssc_master))
        else $error("serial clock pin control wrong");
    chk_tx_float: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ssc_en && !ssc_master && !tx_permit) |=> ssc_ctl_o.tx_tristate)
        else $error("tx pin not tristated");
    chk_p0_ones: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        bus_sel |=> lat0 == `QBP_LATCH_RST)
        else $error("low port latch not filled in bus mode");
    chk_p0_pullup: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (p0_pullup_o != 8'h00) |-> $past(bus_sel && bus_lo_oe_i))
        else $error("open-drain pullup outside bus");
endmodule
`default_nettype wire

// *** qbp_defs.svh ***
`ifndef QBP_DEFS_SVH
`define QBP_DEFS_SVH
// Register byte offsets
`define QBP_OFF_P0 5'h00
`define QBP_OFF_P1 5'h04
`define QBP_OFF_P2 5'h08
`define QBP_OFF_P3 5'h0C
`define QBP_OFF_CTRL 5'h10
`define QBP_OFF_STAT 5'h14
// Reset values and masks
`define QBP_LATCH_RST 8'hFF
`define QBP_P1_MASK 8'h3F
`define QBP_CTRL_RST 3'h0
// Control bit positions
`define QBP_CTL_EN 0
`define QBP_CTL_MASTER 1
`define QBP_CTL_PERMIT 2
// Status field positions
`define QBP_STAT_BUS 24
// Port 1 serial pin indices
`define QBP_SCLK_BIT 2
`define QBP_RX_BIT 3
`define QBP_TX_BIT 4
`define QBP_SEL_BIT 5
// Machine cycle: 6 states of 2 phases each
`define QBP_PHASE_LAST 4'hB
`define QBP_PHASE_S1P1 4'h0
`define QBP_BOOST_PHASES 4'h2
`endif

// *** qbp_pkg.sv ***
package qbp_pkg;
    // Gray sequence along input low, input high, forced high
    typedef enum logic [1:0] {
        QBP_INPUT_LOW = 2'h0,
        QBP_INPUT_HIGH = 2'h1,
        QBP_FORCED_HIGH = 2'h3,
        QBP_OUTPUT_LOW = 2'h2
    } qbp_drv_e;
    typedef struct packed {
        logic [7:0] strong_pulldown_fet;
        logic [7:0] boost_pullup_fet;
        logic [7:0] hold_pullup_fet;
        logic [7:0] sensed_pullup_fet;
    } qbp_qdrv_s;
    typedef struct packed {
        logic sclk_pushpull;
        logic sclk_tristate;
        logic tx_pushpull;
        logic tx_tristate;
        logic rx_tristate;
        logic sel_tristate;
    } qbp_ssc_ctl_s;
    typedef struct packed {
        logic tmr2_count_pin;
        logic tmr2_trigger_pin;
        logic sclk_in;
        logic serial_rx_pin;
        logic serial_select_pin;
    } qbp_p1_alt_s;
    typedef struct packed {
        logic usb_attach_detect;
        logic ext_irq0_gate_pin;
        logic ext_irq1_gate_pin;
        logic tmr0_count_pin;
        logic tmr1_count_pin;
    } qbp_p3_alt_s;
endpackage

// *** qbp_pin_load.sv ***
`timescale 1ns/10ps
`default_nettype none
module qbp_pin_load
(
    input wire logic mclk_i,
    input wire qbp_pkg::qbp_qdrv_s drv_i,
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    output logic [7:0] pin_hi_o
);
    logic drift = 1'h0;
    logic [7:0] pull_up;

    // Floating pins wander, so a missing driver never reads as a steady level
    always_ff @(posedge mclk_i)
        drift <= !drift;

    assign pull_up = drv_i.boost_pullup_fet | drv_i.hold_pullup_fet |
        drv_i.sensed_pullup_fet;

    // External driver wins; otherwise the pin follows the on transistors
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (ext_en_i[i])
                pin_hi_o[i] = ext_val_i[i];
            else if (drv_i.strong_pulldown_fet[i])
                pin_hi_o[i] = 1'h0;
            else if (pull_up[i])
                pin_hi_o[i] = 1'h1;
            else
                pin_hi_o[i] = drift;
        end
    end
endmodule
`default_nettype wire

// *** qbp_port_ctl_tb.sv ***
`timescale 1ns/10ps
`include "qbp_defs.svh"
`default_nettype none
module qbp_port_ctl_tb;
    logic mclk_i;
    logic rst_n_i;
    logic [4:0] addr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic waitreq;
    logic [7:0] pin1, pin2, pin3, bus_lo, bus_hi, alt1, alt3;
    logic [7:0] en1, val1, en2, val2, en3, val3, p0_pd, p0_pu;
    logic cfs_n, ext_fetch, addr16, lo_oe;
    qbp_pkg::qbp_qdrv_s d1, d2, d3;
    qbp_pkg::qbp_ssc_ctl_s sync_serial_unit;
    qbp_pkg::qbp_p1_alt_s a1;
    qbp_pkg::qbp_p3_alt_s a3;
    int errors;
    int comparisons;
    logic [31:0] got;

    qbp_port_ctl dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_readdata_o(rdata),
        .avs_waitrequest_o(waitreq), .p1_pin_hi_i(pin1),
        .p2_pin_hi_i(pin2), .p3_pin_hi_i(pin3),
        .code_fetch_source_pin_n_i(cfs_n), .ext_fetch_i(ext_fetch),
        .addr16_i(addr16), .bus_lo_oe_i(lo_oe), .bus_addr_lo_i(bus_lo),
        .bus_addr_hi_i(bus_hi), .p1_alt_out_i(alt1),
        .p3_alt_out_i(alt3), .p0_pulldown_o(p0_pd), .p0_pullup_o(p0_pu),
        .p1_drv_o(d1), .p2_drv_o(d2), .p3_drv_o(d3), .ssc_ctl_o(sync_serial_unit),
        .p1_alt_in_o(a1), .p3_alt_in_o(a3));
    qbp_pin_load load1 (.mclk_i(mclk_i), .drv_i(d1), .ext_en_i(en1),
        .ext_val_i(val1), .pin_hi_o(pin1));
    qbp_pin_load load2 (.mclk_i(mclk_i), .drv_i(d2), .ext_en_i(en2),
        .ext_val_i(val2), .pin_hi_o(pin2));
    qbp_pin_load load3 (.mclk_i(mclk_i), .drv_i(d3), .ext_en_i(en3),
        .ext_val_i(val3), .pin_hi_o(pin3));

    initial
    begin
        mclk_i = 1'h0;
        forever #25 mclk_i = ~mclk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Request held until the edge that sees waitrequest low
    task automatic bus(input logic is_wr, input logic [4:0] a,
        input logic [31:0] d);
        int n;
        begin
            @(posedge mclk_i);
            addr <= a;
            wdata <= d;
            wr <= is_wr;
            rd <= !is_wr;
            n = 0;
            do
            begin
                @(posedge mclk_i);
                n++;
            end while (waitreq !== 1'h0 && n < 50);
            if (waitreq !== 1'h0)
            begin
                errors++;
                final_report();
            end
            got = rdata;
            wr <= 1'h0;
            rd <= 1'h0;
        end
    endtask

    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        bus(1'h1, a, {24'h000000, d});
    endtask

    task automatic rreg(input logic [4:0] a, input logic [31:0] exp);
        bus(1'h0, a, 32'h00000000);
        check(got, exp);
    endtask

    // Three clocks cover the pin synchroniser plus the output register
    task automatic settle(input int n);
        repeat (n) @(negedge mclk_i);
    endtask

    // 26 clocks, over two machine cycles wide, so the S1 pulse cannot be missed
    task automatic boost_count(input int port, output int cnt,
        output logic [7:0] seen);
        logic [7:0] b;
        begin
            cnt = 0;
            seen = 8'h00;
            repeat (26)
            begin
                @(negedge mclk_i);
                b = (port == 2) ? d2.boost_pullup_fet : d3.boost_pullup_fet;
                if (b !== 8'h00)
                    cnt++;
                seen = seen | b;
            end
        end
    endtask

    initial
    begin
        logic [5:0] e;
        logic [7:0] u;
        int n;
        errors = 0;
        comparisons = 0;
        rst_n_i = 1'h0;
        addr = 5'h00;
        rd = 1'h0;
        wr = 1'h0;
        wdata = 32'h00000000;
        {cfs_n, ext_fetch, addr16, lo_oe} = 4'h8;
        {bus_lo, bus_hi, alt1, alt3} = 32'h0000FFFF;
        {en1, val1, en2, val2, en3, val3} = 48'h000000000000;
        repeat (12) @(posedge mclk_i);
        rst_n_i <= 1'h1;
        @(posedge mclk_i);
        @(negedge mclk_i);
        check(d3.hold_pullup_fet, 8'hFF);
        check(d3.sensed_pullup_fet, 8'h00);
        check(d1.hold_pullup_fet, 8'h3F);
        settle(5);
        check(d3.sensed_pullup_fet, 8'hFF);
        rreg(`QBP_OFF_P0, 32'h000000FF);
        rreg(`QBP_OFF_P1, 32'h0000003F);
        rreg(`QBP_OFF_P2, 32'h000000FF);
        rreg(`QBP_OFF_P3, 32'h000000FF);
        rreg(`QBP_OFF_CTRL, 32'h00000000);
        rreg(5'h18, 32'h00000000);
        $display("test reset done");

        wreg(`QBP_OFF_P3, 8'hFE);
        settle(4);
        check(d3.strong_pulldown_fet, 8'h01);
        check(d3.hold_pullup_fet, 8'hFE);
        check(d3.sensed_pullup_fet, 8'hFE);
        wreg(`QBP_OFF_P3, 8'hFF);
        boost_count(3, n, u);
        check(32'(n), 32'h00000002);
        check(u, 8'h01);
        check(d3.sensed_pullup_fet, 8'hFF);
        check(d3.strong_pulldown_fet, 8'h00);
        wreg(`QBP_OFF_P3, 8'hFF);
        boost_count(3, n, u);
        check(32'(n), 32'h00000000);
        $display("test boost done");

        @(posedge mclk_i);
        en2 <= 8'h01;
        settle(4);
        check(d2.sensed_pullup_fet, 8'hFE);
        check(d2.hold_pullup_fet, 8'hFF);
        wreg(`QBP_OFF_P2, 8'hFE);
        wreg(`QBP_OFF_P2, 8'hFF);
        boost_count(2, n, u);
        check(32'(n), 32'h00000002);
        @(posedge mclk_i);
        en2 <= 8'h00;
        $display("test heavy load done");

        en1 <= 8'h20;
        for (int i = 0; i < 16; i++)
        begin
            wreg(`QBP_OFF_CTRL, {5'h00, i[2:0]});
            val1 <= {2'h0, i[3], 5'h00};
            settle(4);
            if (!i[0])
                e = 6'h00;
            else if (i[1])
                e = 6'h2A;
            else
                e = {3'h3, !(!i[3] && i[2]), 2'h3};
            check({26'h0000000, sync_serial_unit}, {26'h0000000, e});
            u = d1.hold_pullup_fet;
            check(u[`QBP_RX_BIT], !i[0]);
        end
        wreg(`QBP_OFF_CTRL, 8'h00);
        en1 <= 8'h00;
        $display("test serial pins done");

        wreg(`QBP_OFF_P2, 8'h12);
        wreg(`QBP_OFF_P0, 8'h0F);
        settle(2);
        check(p0_pd, 8'hF0);
        check(p0_pu, 8'h00);
        wreg(`QBP_OFF_P0, 8'hFF);
        settle(2);
        check(p0_pd, 8'h00);
        @(posedge mclk_i);
        {bus_hi, bus_lo} <= 16'hA53C;
        {cfs_n, addr16, lo_oe} <= 3'h3;
        settle(4);
        check(d2.boost_pullup_fet, 8'hA5);
        check(d2.hold_pullup_fet, 8'h00);
        check(d2.strong_pulldown_fet, 8'h5A);
        check(p0_pu, 8'h3C);
        check(p0_pd, 8'hC3);
        bus(1'h0, `QBP_OFF_STAT, 32'h00000000);
        check({31'h00000000, got[`QBP_STAT_BUS]}, 32'h00000001);
        wreg(`QBP_OFF_P0, 8'h00);
        rreg(`QBP_OFF_P0, 32'h000000FF);
        rreg(`QBP_OFF_P2, 32'h00000012);
        {cfs_n, ext_fetch, addr16} <= 3'h6;
        settle(4);
        check(d2.strong_pulldown_fet, 8'hED);
        check(d2.hold_pullup_fet, 8'h12);
        @(posedge mclk_i);
        {ext_fetch, lo_oe} <= 2'h0;
        settle(4);
        check(p0_pu, 8'h00);
        check(p0_pd, 8'h00);
        $display("test memory bus done");

        @(posedge mclk_i);
        en3 <= 8'h04;
        alt3 <= 8'hBF;
        wreg(`QBP_OFF_P3, 8'hDF);
        settle(4);
        check({27'h0000000, a3}, 32'h00000016);
        check(d3.strong_pulldown_fet, 8'h60);
        check({27'h0000000, a1}, 32'h0000001F);
        @(posedge mclk_i);
        en1 <= 8'h01;
        alt1 <= 8'hEF;
        settle(4);
        check({27'h0000000, a1}, 32'h0000000F);
        check(d1.strong_pulldown_fet, 8'h10);
        $display("test alternate functions done");
        final_report();
    end
endmodule
`default_nettype wire
